// file: hdl/dip_core.sv
// dual-issue pipeline control: fetch address, queue, staging, issue, routing
// assumes fetch_valid means the cache pair for fetch_addr is present this cycle
`timescale 1ns/1ps
`default_nettype none

module dip_core
  import dip_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic fetch_valid,
  input wire dip_cat_t fetch_cat0,
  input wire dip_cat_t fetch_cat1,
  input wire logic [DIP_ID_W-1:0] fetch_id0,
  input wire logic [DIP_ID_W-1:0] fetch_id1,
  input wire logic jump_taken,
  input wire logic [31:0] jump_target,
  input wire logic predict_hit,
  input wire logic [31:0] predict_target,
  input wire logic exc_req,
  input wire logic [31:0] exc_vector,
  input wire logic exc_ret_req,
  input wire logic [31:0] exception_return_pc,
  input wire logic err_ret_req,
  input wire logic [31:0] error_return_pc,
  output logic [31:0] fetch_addr,
  output logic fetch_hold,
  output logic [1:0] issue_valid,
  output logic [DIP_ID_W-1:0] issue_id0,
  output logic [DIP_ID_W-1:0] issue_id1,
  output logic [DIP_NUM_PIPES-1:0] route0,
  output logic [DIP_NUM_PIPES-1:0] route1,
  output logic [1:0] exec_valid,
  output logic [1:0] data_valid,
  output logic [1:0] wb_reg_we,
  output logic wb_dcache_we,
  output logic [DIP_ID_W-1:0] wb_id0,
  output logic [DIP_ID_W-1:0] wb_id1,
  output logic [DIP_FP_STAGES-1:0] fp_stage_valid,
  output logic fp_commit,
  output logic [DIP_ID_W-1:0] fp_commit_id,
  output logic fp_bypass_write,
  output logic fp_bypass_int_wb
);

  typedef struct packed {
    logic [31:0] pc;
    logic hold;
    dip_entry_t q0;
    dip_entry_t q1;
    dip_entry_t stg;
    dip_entry_t [1:0] r;
    dip_entry_t [1:0] a;
    dip_entry_t [1:0] d;
    dip_entry_t [1:0] w;
    logic [1:0][DIP_NUM_PIPES-1:0] route;
    logic [1:0] a_hold;
    logic [1:0] w_reg;
    logic w_dc;
  } dip_state_t;

  dip_state_t st;
  dip_state_t next_st;

  // shared-resource pair: both multiply units use the one aligner
  function automatic logic dip_shares(input dip_cat_t o, input dip_cat_t y);
    return (o == DIP_CAT_MULLO && y == DIP_CAT_MULHI) || (o == DIP_CAT_MULHI && y == DIP_CAT_MULLO);
  endfunction

  dip_entry_t older;
  dip_entry_t younger;
  dip_entry_t third;
  logic flush;
  logic stall_issue;
  logic slot_o;
  logic iss_o;
  logic iss_y;
  logic pair_ok;
  logic q_take;
  logic r_move;
  logic [DIP_NUM_PIPES-1:0] pipes_o;
  logic [DIP_NUM_PIPES-1:0] pipes_y;
  logic fp_start;
  logic [DIP_ID_W-1:0] fp_start_id;

  always_comb
  begin
    next_st = st;
    flush = exc_req || exc_ret_req || err_ret_req || jump_taken;
    stall_issue = |st.a_hold;
    // staged leftover is always the older of the pair
    older = st.stg.v ? st.stg : st.q0;
    younger = st.stg.v ? st.q0 : st.q1;
    third = st.stg.v ? st.q1 : DIP_EMPTY;
    // older yields slot zero when the younger can only go there
    slot_o = (dip_slot_ok(older.cat, 1'b1) && !dip_slot_ok(younger.cat, 1'b1)) ? 1'b1
             : !dip_slot_ok(older.cat, 1'b0);
    pipes_o = dip_pipes(older.cat, slot_o);
    pipes_y = dip_pipes(younger.cat, !slot_o);
    // no branch or return in a delay slot; no shared physical pipe
    pair_ok = dip_slot_ok(younger.cat, !slot_o) && ((pipes_o & pipes_y) == '0)
              && !(older.cat == DIP_CAT_BRANCH && (younger.cat == DIP_CAT_BRANCH || younger.cat == DIP_CAT_ERET));
    iss_o = older.v && !stall_issue && !flush;
    iss_y = iss_o && younger.v && pair_ok;
    q_take = 1'b0;
    r_move = !stall_issue;

    // integer stages; a held slot keeps its execute entry one more cycle
    for (int s = 0; s < 2; s++)
    begin
      next_st.a_hold[s] = 1'b0;
      if (st.a_hold[s])
      begin
        next_st.d[s] = DIP_EMPTY;
      end
      else
      begin
        next_st.a[s] = r_move ? st.r[s] : DIP_EMPTY;
        next_st.d[s] = st.a[s];
        next_st.a_hold[s] = r_move && st.r[s].v && st.r[s].y;
      end
      next_st.w[s] = st.d[s];
      next_st.w_reg[s] = st.d[s].v && !(st.d[s].cat inside {DIP_CAT_BRANCH, DIP_CAT_SYNC, DIP_CAT_ERET});
    end
    next_st.w_dc = st.d[1].v && st.d[1].cat == DIP_CAT_LDST;

    if (r_move)
    begin
      next_st.r = '{DIP_EMPTY, DIP_EMPTY};
      if (iss_o)
      begin
        next_st.r[slot_o] = older;
        next_st.route[slot_o] = pipes_o;
        next_st.r[slot_o].y = 1'b0;
      end
      if (iss_y)
      begin
        next_st.r[!slot_o] = younger;
        next_st.route[!slot_o] = pipes_y;
        next_st.r[!slot_o].y = dip_shares(older.cat, younger.cat);
      end
    end

    // staging and queue bookkeeping
    if (flush)
    begin
      next_st.stg = DIP_EMPTY;
      next_st.q0 = DIP_EMPTY;
      next_st.q1 = DIP_EMPTY;
    end
    else if (iss_o)
    begin
      if (iss_y)
      begin
        next_st.stg = third;
        next_st.q0 = DIP_EMPTY;
        next_st.q1 = DIP_EMPTY;
        q_take = 1'b1;
      end
      else if (st.stg.v)
      begin
        // two left over: keep one staged, the other waits in the queue
        next_st.stg = st.q0;
        next_st.q0 = st.q1;
        next_st.q1 = DIP_EMPTY;
        q_take = !st.q1.v;
      end
      else
      begin
        next_st.stg = st.q1;
        next_st.q0 = DIP_EMPTY;
        next_st.q1 = DIP_EMPTY;
        q_take = 1'b1;
      end
    end
    else
    begin
      q_take = !st.q0.v;
    end

    // queue load: the pair for fetch_addr, already translated and tag checked
    if (!flush && q_take && fetch_valid)
    begin
      next_st.q0 = '{v: 1'b1, cat: fetch_cat0, id: fetch_id0, y: 1'b0};
      next_st.q1 = '{v: 1'b1, cat: fetch_cat1, id: fetch_id1, y: 1'b0};
    end
    next_st.hold = !flush && !(q_take && fetch_valid);

    // fetch address priority: vector, error return, return, resolved, predicted, sequential
    if (exc_req)
      next_st.pc = exc_vector;
    else if (err_ret_req)
      next_st.pc = error_return_pc;
    else if (exc_ret_req)
      next_st.pc = exception_return_pc;
    else if (jump_taken)
      next_st.pc = jump_target;
    else if (q_take && fetch_valid)
      next_st.pc = predict_hit ? predict_target : st.pc + DIP_FETCH_STRIDE;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
      st.pc <= DIP_RESET_PC;
    end
    else
      st <= next_st;
  end

  // float instruction starts operand fetch as it leaves register fetch
  assign fp_start = r_move && st.r[0].v && st.r[0].cat == DIP_CAT_FPOP;
  assign fp_start_id = st.r[0].id;

  dip_fp_track u_fp (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(fp_start),
    .start_id(fp_start_id),
    .int_wb_move(st.w[1].v && st.w[1].cat == DIP_CAT_FPMOV),
    .stage_valid(fp_stage_valid),
    .commit_id(fp_commit_id),
    .commit(fp_commit),
    .bypass_from_write(fp_bypass_write),
    .bypass_from_int_wb(fp_bypass_int_wb)
  );

  assign fetch_addr = st.pc;
  assign fetch_hold = st.hold;
  assign issue_valid = {st.r[1].v, st.r[0].v};
  assign issue_id0 = st.r[0].id;
  assign issue_id1 = st.r[1].id;
  assign route0 = st.route[0];
  assign route1 = st.route[1];
  assign exec_valid = {st.a[1].v, st.a[0].v};
  assign data_valid = {st.d[1].v, st.d[0].v};
  assign wb_reg_we = st.w_reg;
  assign wb_dcache_we = st.w_dc;
  assign wb_id0 = st.w[0].id;
  assign wb_id1 = st.w[1].id;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_routes_disjoint;
    (&issue_valid) |-> ((route0 & route1) == '0);
  endproperty
  a_routes_disjoint: assert property (p_routes_disjoint) else $error("two slots share a physical pipe");

  property p_stage_order;
    (st.r[0].v && !stall_issue) |=> st.a[0].v ##1 st.d[0].v ##1 (st.w[0].v && wb_id0 == $past(issue_id0, 3));
  endproperty
  a_stage_order: assert property (p_stage_order) else $error("slot zero did not walk execute, data, writeback");

  property p_vector;
    exc_req |=> fetch_addr == $past(exc_vector);
  endproperty
  a_vector: assert property (p_vector) else $error("exception vector not selected");

  property p_jump;
    (jump_taken && !exc_req && !exc_ret_req && !err_ret_req) |=> fetch_addr == $past(jump_target) && !issue_valid[0];
  endproperty
  a_jump: assert property (p_jump) else $error("resolved jump not selected or queue not cleared");

  property p_staged_first;
    (st.stg.v && !flush && !stall_issue) |=> (issue_valid[0] && issue_id0 == $past(st.stg.id))
      || (issue_valid[1] && issue_id1 == $past(st.stg.id));
  endproperty
  a_staged_first: assert property (p_staged_first) else $error("staged instruction not retried");

  property p_younger_stall;
    (st.r[1].v && st.r[1].y && !stall_issue) |=> st.a[1].v ##1 (st.a[1].v && !st.d[1].v);
  endproperty
  a_younger_stall: assert property (p_younger_stall) else $error("younger did not stall one cycle in execute");

  property p_wide_route;
    (st.r[0].v && st.r[0].cat == DIP_CAT_WIDE) |-> route0[DIP_PIPE_INT0] && route0[DIP_PIPE_INT1] && !issue_valid[1];
  endproperty
  a_wide_route: assert property (p_wide_route) else $error("wide operate not on both integer pipes");

  property p_fpop_route;
    (st.r[0].v && st.r[0].cat == DIP_CAT_FPOP) |-> route0 == 5'h11;
  endproperty
  a_fpop_route: assert property (p_fpop_route) else $error("float operate misrouted");

  property p_fetch_held;
    (!flush && !(q_take && fetch_valid)) |=> fetch_hold && $stable(fetch_addr);
  endproperty
  a_fetch_held: assert property (p_fetch_held) else $error("fetch moved while queue was full");

  c_dual: cover property (&issue_valid);
  c_ystall: cover property (|st.a_hold);
  c_staged: cover property (st.stg.v ##1 st.stg.v);
  c_fp: cover property (fp_commit);

endmodule

`default_nettype wire

// file: hdl/dip_pkg.sv
// shared constants and types for the dual-issue pipeline control block
// assumes a single core clock; every stage is one clock, two phases inside it
package dip_pkg;

  // instruction categories, one issuing policy each
  typedef enum logic [3:0] {
    DIP_CAT_ALU    = 4'h0,
    DIP_CAT_BRANCH = 4'h1,
    DIP_CAT_WIDE   = 4'h2,
    DIP_CAT_SHIFTAMT = 4'h3,
    DIP_CAT_MULLO = 4'h4,
    DIP_CAT_FPOP   = 4'h5,
    DIP_CAT_SYNC   = 4'h6,
    DIP_CAT_ERET   = 4'h7,
    DIP_CAT_LDST = 4'h8,
    DIP_CAT_FPMOV = 4'h9,
    DIP_CAT_SYSCOP = 4'hA,
    DIP_CAT_MULHI = 4'hB
  } dip_cat_t;

  // physical pipe one-hot bit positions
  localparam int DIP_PIPE_INT0 = 0;
  localparam int DIP_PIPE_INT1 = 1;
  localparam int DIP_PIPE_LDST = 2;
  localparam int DIP_PIPE_JUMP = 3;
  localparam int DIP_PIPE_FLT = 4;
  localparam int DIP_NUM_PIPES = 5;

  localparam logic [31:0] DIP_RESET_PC = 32'h0000_0000;
  localparam logic [31:0] DIP_FETCH_STRIDE = 32'h0000_0008;
  localparam int DIP_ID_W = 8;
  localparam int DIP_FP_STAGES = 5;

  typedef struct packed {
    logic v;
    dip_cat_t cat;
    logic [DIP_ID_W-1:0] id;
    logic y;
  } dip_entry_t;

  localparam dip_entry_t DIP_EMPTY = '{v: 1'b0, cat: DIP_CAT_ALU, id: 8'h00, y: 1'b0};

  // which logical issue slot may carry a category
  function automatic logic dip_slot_ok(input dip_cat_t c, input logic slot);
    logic ok;
    ok = 1'b0;
    case (c)
      DIP_CAT_ALU, DIP_CAT_BRANCH: ok = 1'b1;
      DIP_CAT_WIDE, DIP_CAT_SHIFTAMT, DIP_CAT_MULLO, DIP_CAT_FPOP: ok = !slot;
      default: ok = slot;
    endcase
    return ok;
  endfunction

  // physical pipes that a category occupies from a given slot
  function automatic logic [DIP_NUM_PIPES-1:0] dip_pipes(input dip_cat_t c, input logic slot);
    logic [DIP_NUM_PIPES-1:0] p;
    p = '0;
    case (c)
      DIP_CAT_ALU: p[slot ? DIP_PIPE_INT1 : DIP_PIPE_INT0] = 1'b1;
      DIP_CAT_BRANCH: p[DIP_PIPE_JUMP] = 1'b1;
      DIP_CAT_WIDE:
      begin
        p[DIP_PIPE_INT0] = 1'b1;
        p[DIP_PIPE_INT1] = 1'b1;
      end
      DIP_CAT_SHIFTAMT, DIP_CAT_MULLO: p[DIP_PIPE_INT0] = 1'b1;
      DIP_CAT_FPOP:
      begin
        p[DIP_PIPE_INT0] = 1'b1;
        p[DIP_PIPE_FLT] = 1'b1;
      end
      DIP_CAT_FPMOV:
      begin
        p[DIP_PIPE_LDST] = 1'b1;
        p[DIP_PIPE_FLT] = 1'b1;
      end
      DIP_CAT_MULHI: p[DIP_PIPE_INT1] = 1'b1;
      default: p[DIP_PIPE_LDST] = 1'b1;
    endcase
    return p;
  endfunction

endpackage

// file: hdl/dip_fp_track.sv
// floating-point pipe tracker: operand fetch, three execute steps, write
// assumes start pulses in the cycle a float instruction leaves register fetch
`timescale 1ns/1ps
`default_nettype none

module dip_fp_track
  import dip_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [DIP_ID_W-1:0] start_id,
  input wire logic int_wb_move,
  output logic [DIP_FP_STAGES-1:0] stage_valid,
  output logic [DIP_ID_W-1:0] commit_id,
  output logic commit,
  output logic bypass_from_write,
  output logic bypass_from_int_wb
);

  typedef struct packed {
    logic [DIP_FP_STAGES-1:0] v;
    logic [DIP_FP_STAGES-1:0][DIP_ID_W-1:0] id;
    logic byp_s;
    logic byp_w;
  } dip_fp_state_t;

  dip_fp_state_t st;
  dip_fp_state_t next_st;

  always_comb
  begin
    next_st = st;
    // operand fetch, exception screen, multiply/align, normalize and round, write
    next_st.v = {st.v[DIP_FP_STAGES-2:0], start};
    next_st.id = {st.id[DIP_FP_STAGES-2:0], start_id};
    // forwarding select when write and operand fetch overlap
    next_st.byp_s = start && st.v[DIP_FP_STAGES-2];
    next_st.byp_w = start && int_wb_move;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign stage_valid = st.v;
  assign commit = st.v[DIP_FP_STAGES-1];
  assign commit_id = st.id[DIP_FP_STAGES-1];
  assign bypass_from_write = st.byp_s;
  assign bypass_from_int_wb = st.byp_w;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_fp_depth;
    start |=> ##4 (commit && commit_id == $past(start_id, 5));
  endproperty
  a_fp_depth: assert property (p_fp_depth) else $error("float op did not commit after five stages");

  property p_fp_bypass;
    (start && st.v[DIP_FP_STAGES-2]) |=> bypass_from_write && commit;
  endproperty
  a_fp_bypass: assert property (p_fp_bypass) else $error("write-to-fetch forward missed");

  c_fp_overlap: cover property (start ##1 start ##1 start);

endmodule

`default_nettype wire

// file: sim/dual_issue_pipeline_routing_test.sv
// self-checking bench for the dual-issue pipeline control block
// assumes dip_pkg and dip_core are compiled first; all dip_core outputs are flops
`timescale 1ns/1ps
`default_nettype none

module dual_issue_pipeline_routing_test
  import dip_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic fetch_valid = 1'b0;
  dip_cat_t fetch_cat0 = DIP_CAT_ALU;
  dip_cat_t fetch_cat1 = DIP_CAT_ALU;
  logic [7:0] fetch_id0 = 8'h00;
  logic [7:0] fetch_id1 = 8'h00;
  logic jump_taken = 1'b0;
  logic predict_hit = 1'b0;
  logic exc_req = 1'b0;
  logic exc_ret_req = 1'b0;
  logic err_ret_req = 1'b0;
  logic [31:0] jump_target = 32'h0000_3000;
  logic [31:0] predict_target = 32'h0000_4000;
  logic [31:0] exc_vector = 32'h0000_0180;
  logic [31:0] exception_return_pc = 32'h0000_2000;
  logic [31:0] error_return_pc = 32'h0000_1000;
  logic [31:0] fetch_addr;
  logic fetch_hold;
  logic [1:0] issue_valid;
  logic [7:0] issue_id0;
  logic [7:0] issue_id1;
  logic [4:0] route0;
  logic [4:0] route1;
  logic [1:0] exec_valid;
  logic [1:0] data_valid;
  logic [1:0] wb_reg_we;
  logic wb_dcache_we;
  logic [7:0] wb_id0;
  logic [7:0] wb_id1;
  logic [4:0] fp_stage_valid;
  logic fp_commit;
  logic [7:0] fp_commit_id;
  logic fp_bypass_write;
  logic fp_bypass_int_wb;
  int err_count = 0;
  int cmp_count = 0;
  // every category at least once; the third pair is refused once, leftovers keep the staging busy
  dip_cat_t stream_cat [16] = '{DIP_CAT_WIDE, DIP_CAT_FPOP, DIP_CAT_SHIFTAMT, DIP_CAT_LDST, DIP_CAT_BRANCH,
    DIP_CAT_BRANCH, DIP_CAT_MULLO, DIP_CAT_MULHI, DIP_CAT_ALU, DIP_CAT_SYSCOP, DIP_CAT_FPOP, DIP_CAT_FPMOV,
    DIP_CAT_ALU, DIP_CAT_SYNC, DIP_CAT_BRANCH, DIP_CAT_ERET};

  always #5 clk_sys = ~clk_sys;

  dip_core dip_core_inst (.clk_sys(clk_sys), .rst_n(rst_n), .fetch_valid(fetch_valid), .fetch_cat0(fetch_cat0),
    .fetch_cat1(fetch_cat1), .fetch_id0(fetch_id0), .fetch_id1(fetch_id1), .jump_taken(jump_taken),
    .jump_target(jump_target), .predict_hit(predict_hit), .predict_target(predict_target), .exc_req(exc_req),
    .exc_vector(exc_vector), .exc_ret_req(exc_ret_req), .exception_return_pc(exception_return_pc),
    .err_ret_req(err_ret_req), .error_return_pc(error_return_pc), .fetch_addr(fetch_addr),
    .fetch_hold(fetch_hold), .issue_valid(issue_valid), .issue_id0(issue_id0), .issue_id1(issue_id1),
    .route0(route0), .route1(route1), .exec_valid(exec_valid), .data_valid(data_valid), .wb_reg_we(wb_reg_we),
    .wb_dcache_we(wb_dcache_we), .wb_id0(wb_id0), .wb_id1(wb_id1), .fp_stage_valid(fp_stage_valid),
    .fp_commit(fp_commit), .fp_commit_id(fp_commit_id), .fp_bypass_write(fp_bypass_write),
    .fp_bypass_int_wb(fp_bypass_int_wb));

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // inputs always change 1 ns after the edge, outputs are settled by then
  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask

  // pipes per category and slot; 5'h1f marks a slot the category may not use
  function automatic logic [4:0] exp_route(input dip_cat_t c, input logic slot);
    case (c)
      DIP_CAT_ALU: return slot ? 5'h02 : 5'h01;
      DIP_CAT_BRANCH: return 5'h08;
      DIP_CAT_WIDE: return slot ? 5'h1f : 5'h03;
      DIP_CAT_SHIFTAMT, DIP_CAT_MULLO: return slot ? 5'h1f : 5'h01;
      DIP_CAT_FPOP: return slot ? 5'h1f : 5'h11;
      DIP_CAT_FPMOV: return slot ? 5'h14 : 5'h1f;
      DIP_CAT_MULHI: return slot ? 5'h02 : 5'h1f;
      default: return slot ? 5'h04 : 5'h1f;
    endcase
  endfunction

  task automatic timed_pair();
    logic [31:0] a0;
    a0 = fetch_addr;
    fetch_valid = 1'b1;
    fetch_cat0 = DIP_CAT_FPOP;
    fetch_cat1 = DIP_CAT_ALU;
    fetch_id0 = 8'h50;
    fetch_id1 = 8'h51;
    step();
    fetch_valid = 1'b0;
    check(fetch_addr, a0 + DIP_FETCH_STRIDE);
    check(32'(issue_valid), 32'h0);
    step();
    check(32'(issue_valid), 32'h3);
    check(32'({issue_id0, issue_id1}), 32'h5051);
    check(32'(route0), 32'h11);
    check(32'(route1), 32'h02);
    step();
    check(32'(exec_valid), 32'h3);
    check(32'(fp_stage_valid), 32'h01);
    step();
    check(32'(data_valid), 32'h3);
    check(32'(fp_stage_valid), 32'h02);
    step();
    check(32'({wb_reg_we[1], wb_id1}), 32'h151);
    check(32'(fp_stage_valid), 32'h04);
    step();
    check(32'(fp_stage_valid), 32'h08);
    step();
    check(32'({fp_stage_valid, fp_commit, fp_commit_id}), 32'h2150);
    repeat (3) step();
    $display("timed pair test done");
  endtask

  // multiply pair stalls the younger in execute; float ops four apart forward from write
  task automatic stall_forward();
    fetch_valid = 1'b1;
    fetch_cat0 = DIP_CAT_MULLO;
    fetch_cat1 = DIP_CAT_MULHI;
    fetch_id0 = 8'h60;
    fetch_id1 = 8'h61;
    step();
    fetch_valid = 1'b0;
    step();
    check(32'({issue_valid, issue_id0, issue_id1}), 32'h0003_6061);
    check(32'({route0, route1}), 32'h22);
    step();
    check(32'(exec_valid), 32'h3);
    step();
    check(32'({exec_valid, data_valid}), 32'h9);
    step();
    check(32'({exec_valid, data_valid, wb_reg_we}), 32'h9);
    step();
    check(32'({wb_reg_we, wb_id1}), 32'h261);
    fetch_valid = 1'b1;
    fetch_cat0 = DIP_CAT_FPOP;
    fetch_cat1 = DIP_CAT_LDST;
    fetch_id0 = 8'h62;
    fetch_id1 = 8'h63;
    step();
    fetch_valid = 1'b0;
    repeat (3) step();
    fetch_valid = 1'b1;
    fetch_cat1 = DIP_CAT_ALU;
    fetch_id0 = 8'h64;
    fetch_id1 = 8'h65;
    step();
    fetch_valid = 1'b0;
    check(32'({wb_dcache_we, wb_id0, wb_id1}), 32'h0001_6263);
    repeat (2) step();
    check(32'({fp_bypass_int_wb, fp_bypass_write, fp_commit, fp_commit_id}), 32'h362);
    repeat (6) step();
    $display("stall and forward test done");
  endtask

  task automatic redirects();
    logic [3:0] req;
    // leftover in staging must vanish when fetch is redirected
    fetch_valid = 1'b1;
    fetch_cat0 = DIP_CAT_WIDE;
    fetch_cat1 = DIP_CAT_FPOP;
    step();
    fetch_valid = 1'b0;
    step();
    jump_taken = 1'b1;
    step();
    jump_taken = 1'b0;
    check(fetch_addr, jump_target);
    check(32'(issue_valid), 32'h0);
    step();
    check(32'(issue_valid), 32'h0);
    for (int k = 0; k < 4; k++)
    begin
      req = 4'hf >> k;
      {exc_req, err_ret_req, exc_ret_req, jump_taken} = req;
      step();
      {exc_req, err_ret_req, exc_ret_req, jump_taken} = 4'h0;
      check(fetch_addr, req[3] ? exc_vector : req[2] ? error_return_pc :
        req[1] ? exception_return_pc : jump_target);
    end
    fetch_valid = 1'b1;
    fetch_cat0 = DIP_CAT_ALU;
    predict_hit = 1'b1;
    step();
    fetch_valid = 1'b0;
    predict_hit = 1'b0;
    check(fetch_addr, predict_target);
    repeat (8) step();
    $display("redirect test done");
  endtask

  task automatic run_stream(input logic [7:0] idb);
    logic [31:0] base;
    logic [31:0] prev;
    logic [7:0] got[$];
    logic saw_hold;
    logic swap;
    int idx;
    int guard;
    base = fetch_addr;
    prev = fetch_addr;
    saw_hold = 1'b0;
    guard = 0;
    while (got.size() < 16)
    begin
      if (guard == 150)
      begin
        err_count++;
        $display("ERROR at %0t: stream stuck, seen %h expected %h", $time, got.size(), 16);
        complete_run();
      end
      guard++;
      swap = (issue_valid === 2'b11) && (issue_id1 < issue_id0);
      if (issue_valid[0] === 1'b1)
        check(32'(route0), 32'(exp_route(stream_cat[4'(issue_id0 - idb)], 1'b0)));
      if (issue_valid[1] === 1'b1)
        check(32'(route1), 32'(exp_route(stream_cat[4'(issue_id1 - idb)], 1'b1)));
      if (swap)
        got.push_back(issue_id1);
      if (issue_valid[0] === 1'b1)
        got.push_back(issue_id0);
      if (issue_valid[1] === 1'b1 && !swap)
        got.push_back(issue_id1);
      if (fetch_hold === 1'b1)
      begin
        // only a pair that was offered and refused counts
        saw_hold = saw_hold || fetch_valid;
        check(fetch_addr, prev);
      end
      prev = fetch_addr;
      idx = int'((fetch_addr - base) >> 3);
      fetch_valid = (idx < 8);
      fetch_cat0 = stream_cat[2 * (idx % 8)];
      fetch_cat1 = stream_cat[2 * (idx % 8) + 1];
      fetch_id0 = idb + 8'(2 * idx);
      fetch_id1 = idb + 8'(2 * idx + 1);
      step();
    end
    fetch_valid = 1'b0;
    for (int i = 0; i < 16; i++)
      check(32'(got[i]), 32'(idb + 8'(i)));
    check(32'(saw_hold), 32'h1);
    $display("stream test done");
  endtask

  initial
  begin
    repeat (12) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    check(fetch_addr, DIP_RESET_PC);
    check(32'({fetch_hold, issue_valid, exec_valid, wb_reg_we}), 32'h0);
    $display("reset test done");
    timed_pair();
    stall_forward();
    redirects();
    run_stream(8'h80);
    complete_run();
  end
endmodule

`default_nettype wire
